/* hdl/gpe_pkg.sv */
// Package for the port E/F/G general-purpose I/O block.
// Assumes a 32-bit AXI4-Lite register bus; offsets are indices, byte address = 4 * index.
package gpe_pkg;
    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [11:0] PORT_E_DATA_IDX = 12'h008;
    localparam logic [11:0] PORT_F_DATA_IDX = 12'h440;
    localparam logic [11:0] PORT_G_DATA_IDX = 12'h441;
    localparam logic [11:0] PORT_E_DIR_IDX = 12'h00C;
    localparam logic [11:0] PORT_F_DIR_IDX = 12'h444;
    localparam logic [11:0] PORT_G_DIR_IDX = 12'h445;
    localparam logic [11:0] PERIPH_CTRL_IDX = 12'h450;
    localparam int ADDR_W = 14;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int PORT_E_W = 6;
    localparam int PORT_FG_W = 8;
    localparam int SER_TX_BIT = 0;
    localparam int SER_RX_BIT = 1;
    localparam int TIMER_PIN_LO = 4;
    localparam int TIMER_CH_N = 4;
    localparam int CTRL_SER_EN_POS = 0;
    localparam int CTRL_ADC_EN_POS = 1;
    localparam int CTRL_ADC_CH_POS = 4;
    localparam int CTRL_ELS_POS = 8;
    localparam int ADC_CH_W = 3;
    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Read-source mux: latch where output, pin where input
    function automatic logic [7:0] gpe_read_mux(input logic [7:0] dir, input logic [7:0] latch,
                                                input logic [7:0] pin);
        gpe_read_mux = (dir & latch) | (~dir & pin);
    endfunction
    // Byte-address to index; bits [1:0] ignored for aligned words
    function automatic logic [11:0] gpe_index(input logic [ADDR_W-1:0] addr);
        gpe_index = addr[ADDR_W-1:2];
    endfunction
endpackage

/* hdl/gpe_sync2.sv */
// Two-flop synchroniser for the pin levels.
// Assumes the sampled pins are asynchronous to sys_clk.
`timescale 1ns/100ps
module gpe_sync2 #(
    parameter int W = 8
) (
    input wire logic sys_clk, // Bus clock
    input wire logic [W-1:0] asyncIn, // Raw pin levels
    output logic [W-1:0] syncOut // Synchronised levels
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    // Stage one is read only by stage two; no reset, pins are don't-care at reset
    always_ff @(posedge sys_clk) begin
        stage1_reg <= asyncIn;
        stage2_reg <= stage1_reg;
    end
    assign syncOut = stage2_reg;
endmodule

/* hdl/gpe_ports.sv */
// Ports E, F and G: data latches, direction registers, pin muxing and AXI4-Lite slave.
// Assumes pads resolve pin level from output and active-low output enable outside.
// Summary of operation
// - Serial enable set: port E bit 0 carries transmit output, else plain I/O.
// - Direction 1 drives pin as output; direction 0 releases it as input.
// - Reset clears all direction bits so every pin is an input.
// - Port E data read: latch where direction 1, synced pin where 0.
// - Port F data read: latch for outputs, pin level for inputs.
// - Port G data read: latch for outputs, pin level for inputs.
// - Data writes always update the latch; input reads still show the pin.
// - Data latches keep contents through reset.
// - Port F upper four pins become timer channels when selects choose so.
// - Selected analog channel pin on port G is forced to analog input.
// - Unselected port G pins stay ordinary digital I/O.
// - Direction: six bits for port E, eight for F and G.
// - Serial enable set: port E bit 1 feeds receiver input, else plain I/O.
// - Serial pins ignore direction for driving, but direction still picks read source.
`timescale 1ns/100ps
module gpe_ports
    import gpe_pkg::*;
(
    input wire logic sys_clk, // 25 MHz bus clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [PORT_E_W-1:0] portEIn, // Port E pin levels
    output logic [PORT_E_W-1:0] portEOut, // Port E pin drive
    output logic [PORT_E_W-1:0] portEOe_n, // Port E enable, low drives
    input wire logic [PORT_FG_W-1:0] portFIn, // Port F pin levels
    output logic [PORT_FG_W-1:0] portFOut, // Port F pin drive
    output logic [PORT_FG_W-1:0] portFOe_n, // Port F enable, low drives
    input wire logic [PORT_FG_W-1:0] portGIn, // Port G pin levels
    output logic [PORT_FG_W-1:0] portGOut, // Port G pin drive
    output logic [PORT_FG_W-1:0] portGOe_n, // Port G enable, low drives
    output logic [PORT_FG_W-1:0] analogSelect, // One-hot analog switch to converter
    input wire logic serialTxData, // Serial transmitter output
    output logic serialRxData, // Serial receiver input
    input wire logic [TIMER_CH_N-1:0] timerOut, // Timer compare outputs
    input wire logic [TIMER_CH_N-1:0] timerOutEn, // Timer drives pin
    output logic [TIMER_CH_N-1:0] timerIn // Timer capture inputs
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [PORT_E_W-1:0] portEData_reg, portEData_next;
    logic [PORT_FG_W-1:0] portFData_reg, portFData_next;
    logic [PORT_FG_W-1:0] portGData_reg, portGData_next;
    logic [PORT_E_W-1:0] portEDir_reg, portEDir_next;
    logic [PORT_FG_W-1:0] portFDir_reg, portFDir_next;
    logic [PORT_FG_W-1:0] portGDir_reg, portGDir_next;
    logic serialEnable_reg, serialEnable_next;
    logic adcEnable_reg, adcEnable_next;
    logic [ADC_CH_W-1:0] adcChannel_reg, adcChannel_next;
    logic [2*TIMER_CH_N-1:0] edgeLevel_reg, edgeLevel_next;
    logic [PORT_E_W-1:0] pinESync;
    logic [PORT_FG_W-1:0] pinFSync, pinGSync;

    typedef enum logic [1:0] {WR_IDLE, WR_ADDR, WR_DATA, WR_RESP} gpe_wr_t;
    gpe_wr_t wrState_reg, wrState_next;
    logic [ADDR_W-1:0] wrAddr_reg, wrAddr_next;
    logic [31:0] wrData_reg, wrData_next;
    logic [3:0] wrStrb_reg, wrStrb_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic doWrite;
    logic [7:0] ctrlWord;
    logic [TIMER_CH_N-1:0] timerPin;
    logic [PORT_FG_W-1:0] analogMask;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    gpe_sync2 #(.W(PORT_E_W)) syncE (.sys_clk(sys_clk), .asyncIn(portEIn), .syncOut(pinESync));
    gpe_sync2 #(.W(PORT_FG_W)) syncF (.sys_clk(sys_clk), .asyncIn(portFIn), .syncOut(pinFSync));
    gpe_sync2 #(.W(PORT_FG_W)) syncG (.sys_clk(sys_clk), .asyncIn(portGIn), .syncOut(pinGSync));

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data accepted in either order; response after both
    always_comb begin
        wrState_next = wrState_reg;
        wrAddr_next = wrAddr_reg;
        wrData_next = wrData_reg;
        wrStrb_next = wrStrb_reg;
        doWrite = 1'b0;
        unique case (wrState_reg)
            WR_IDLE: begin
                if (s_axi_awvalid && s_axi_wvalid) begin
                    wrAddr_next = s_axi_awaddr;
                    wrData_next = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                                 {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
                    wrState_next = WR_RESP;
                    doWrite = s_axi_wstrb[0];
                end else if (s_axi_awvalid) begin
                    wrAddr_next = s_axi_awaddr;
                    wrState_next = WR_DATA;
                end else if (s_axi_wvalid) begin
                    wrData_next = s_axi_wdata;
                    wrStrb_next = s_axi_wstrb; // Lanes kept until the address arrives
                    wrState_next = WR_ADDR;
                end
            end
            WR_ADDR: begin
                if (s_axi_awvalid) begin
                    wrAddr_next = s_axi_awaddr;
                    wrState_next = WR_RESP;
                    doWrite = wrStrb_reg[0];
                end
            end
            WR_DATA: begin
                if (s_axi_wvalid) begin
                    wrData_next = s_axi_wdata;
                    wrState_next = WR_RESP;
                    doWrite = s_axi_wstrb[0];
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wrState_next = WR_IDLE;
                end
            end
        endcase
    end
    assign s_axi_awready = (wrState_reg == WR_IDLE) || (wrState_reg == WR_ADDR);
    assign s_axi_wready = (wrState_reg == WR_IDLE) || (wrState_reg == WR_DATA);
    assign s_axi_bvalid = (wrState_reg == WR_RESP);
    assign s_axi_bresp = bresp_reg;

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    // Low byte lane holds register bits, lane 1 the control edge/level selects; upper lanes are dropped
    logic [ADDR_W-1:0] wAddr;
    logic [7:0] wByte;
    always_comb begin
        wAddr = (wrState_reg == WR_DATA) ? wrAddr_reg : s_axi_awaddr; // Held address only once taken alone
        wByte = (wrState_reg == WR_ADDR) ? wrData_reg[7:0] : s_axi_wdata[7:0];
        portEData_next = portEData_reg;
        portFData_next = portFData_reg;
        portGData_next = portGData_reg;
        portEDir_next = portEDir_reg;
        portFDir_next = portFDir_reg;
        portGDir_next = portGDir_reg;
        serialEnable_next = serialEnable_reg;
        adcEnable_next = adcEnable_reg;
        adcChannel_next = adcChannel_reg;
        edgeLevel_next = edgeLevel_reg;
        bresp_next = bresp_reg;
        if (doWrite || (wrState_next == WR_RESP && wrState_reg != WR_RESP)) begin
            bresp_next = RESP_OKAY;
            if (doWrite) begin
                unique case (gpe_index(wAddr))
                    PORT_E_DATA_IDX: portEData_next = wByte[PORT_E_W-1:0];
                    PORT_F_DATA_IDX: portFData_next = wByte;
                    PORT_G_DATA_IDX: portGData_next = wByte;
                    PORT_E_DIR_IDX: portEDir_next = wByte[PORT_E_W-1:0];
                    PORT_F_DIR_IDX: portFDir_next = wByte;
                    PORT_G_DIR_IDX: portGDir_next = wByte;
                    PERIPH_CTRL_IDX: begin
                        serialEnable_next = wByte[CTRL_SER_EN_POS];
                        adcEnable_next = wByte[CTRL_ADC_EN_POS];
                        adcChannel_next = wByte[CTRL_ADC_CH_POS +: ADC_CH_W];
                        if ((wrState_reg == WR_ADDR) ? wrStrb_reg[1] : s_axi_wstrb[1])
                            edgeLevel_next = (wrState_reg == WR_ADDR) ? wrData_reg[CTRL_ELS_POS +: 8]
                                                                      : s_axi_wdata[CTRL_ELS_POS +: 8];
                    end
                    default: bresp_next = RESP_SLVERR;
                endcase
            end else if (!(gpe_index(wAddr) inside {PORT_E_DATA_IDX, PORT_F_DATA_IDX, PORT_G_DATA_IDX,
                           PORT_E_DIR_IDX, PORT_F_DIR_IDX, PORT_G_DIR_IDX, PERIPH_CTRL_IDX})) begin
                bresp_next = RESP_SLVERR;
            end
        end
    end

    // Data latches carry no reset term, so they hold through reset
    always_ff @(posedge sys_clk) begin
        portEData_reg <= portEData_next;
        portFData_reg <= portFData_next;
        portGData_reg <= portGData_next;
    end

    // Control and bus state
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            portEDir_reg <= DIR_RESET[PORT_E_W-1:0];
            portFDir_reg <= DIR_RESET;
            portGDir_reg <= DIR_RESET;
            serialEnable_reg <= 1'b0;
            adcEnable_reg <= 1'b0;
            adcChannel_reg <= '0;
            edgeLevel_reg <= '0;
            wrState_reg <= WR_IDLE;
            wrAddr_reg <= '0;
            wrData_reg <= '0;
            wrStrb_reg <= '0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            portEDir_reg <= portEDir_next;
            portFDir_reg <= portFDir_next;
            portGDir_reg <= portGDir_next;
            serialEnable_reg <= serialEnable_next;
            adcEnable_reg <= adcEnable_next;
            adcChannel_reg <= adcChannel_next;
            edgeLevel_reg <= edgeLevel_next;
            wrState_reg <= wrState_next;
            wrAddr_reg <= wrAddr_next;
            wrData_reg <= wrData_next;
            wrStrb_reg <= wrStrb_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    // Read data captured at address handshake; one read in flight
    assign ctrlWord = {1'b0, adcChannel_reg, 2'b00, adcEnable_reg, serialEnable_reg};
    assign s_axi_arready = !rvalid_reg;
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (!rvalid_reg && s_axi_arvalid) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            unique case (gpe_index(s_axi_araddr))
                PORT_E_DATA_IDX: rdata_next[7:0] = gpe_read_mux({2'b00, portEDir_reg}, {2'b00, portEData_reg},
                                                                {2'b00, pinESync});
                PORT_F_DATA_IDX: rdata_next[7:0] = gpe_read_mux(portFDir_reg, portFData_reg, pinFSync);
                PORT_G_DATA_IDX: rdata_next[7:0] = gpe_read_mux(portGDir_reg, portGData_reg, pinGSync);
                PORT_E_DIR_IDX: rdata_next[PORT_E_W-1:0] = portEDir_reg;
                PORT_F_DIR_IDX: rdata_next[7:0] = portFDir_reg;
                PORT_G_DIR_IDX: rdata_next[7:0] = portGDir_reg;
                PERIPH_CTRL_IDX: rdata_next[15:0] = {edgeLevel_reg, ctrlWord};
                default: rresp_next = RESP_SLVERR;
            endcase
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ------------------------------------------------------------
    // Pin muxing
    // ------------------------------------------------------------
    // Timer owns a pin when either select bit of its channel is set
    always_comb begin
        for (int i = 0; i < TIMER_CH_N; i++) begin
            timerPin[i] = edgeLevel_reg[2*i] | edgeLevel_reg[2*i+1];
        end
        analogMask = adcEnable_reg ? (8'h01 << adcChannel_reg) : 8'h00;
    end

    // Port E: serial pins override direction, others follow direction
    always_comb begin
        portEOut = portEData_reg;
        portEOe_n = ~portEDir_reg;
        if (serialEnable_reg) begin
            portEOut[SER_TX_BIT] = serialTxData;
            portEOe_n[SER_TX_BIT] = 1'b0;
            portEOe_n[SER_RX_BIT] = 1'b1;
        end
        serialRxData = serialEnable_reg ? pinESync[SER_RX_BIT] : 1'b1;
    end

    // Port F: upper four pins handed to the timer when selected
    always_comb begin
        portFOut = portFData_reg;
        portFOe_n = ~portFDir_reg;
        for (int i = 0; i < TIMER_CH_N; i++) begin
            if (timerPin[i]) begin
                portFOut[TIMER_PIN_LO+i] = timerOut[i];
                portFOe_n[TIMER_PIN_LO+i] = ~timerOutEn[i];
            end
        end
        timerIn = pinFSync[TIMER_PIN_LO +: TIMER_CH_N] & timerPin;
    end

    // Port G: analog channel releases the driver, rest stay digital
    assign portGOut = portGData_reg;
    assign portGOe_n = ~portGDir_reg | analogMask;
    assign analogSelect = analogMask;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_dir_reset: assert property (@(posedge sys_clk) !reset_n |=> portFDir_reg == 8'h00 && portGDir_reg == 8'h00)
        else $error("direction not cleared by reset");
    chk_e_upper_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_axi_rvalid && $past(gpe_index(s_axi_araddr)) == PORT_E_DATA_IDX && $rose(s_axi_rvalid)
        |-> s_axi_rdata[31:PORT_E_W] == '0) else $error("port E upper bits not zero");
    chk_f_read_mux: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(s_axi_rvalid) && $past(gpe_index(s_axi_araddr)) == PORT_F_DATA_IDX
        |-> s_axi_rdata[7:0] == $past(gpe_read_mux(portFDir_reg, portFData_reg, pinFSync)))
        else $error("port F read source wrong");
    chk_g_read_mux: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(s_axi_rvalid) && $past(gpe_index(s_axi_araddr)) == PORT_G_DATA_IDX
        |-> s_axi_rdata[7:0] == $past(gpe_read_mux(portGDir_reg, portGData_reg, pinGSync)))
        else $error("port G read source wrong");
    chk_tx_owns_pin: assert property (@(posedge sys_clk) disable iff (!reset_n)
        serialEnable_reg |-> !portEOe_n[SER_TX_BIT] && portEOut[SER_TX_BIT] == serialTxData)
        else $error("transmit pin not driven");
    chk_rx_released: assert property (@(posedge sys_clk) disable iff (!reset_n)
        serialEnable_reg |-> portEOe_n[SER_RX_BIT]) else $error("receive pin driven");
    chk_analog_float: assert property (@(posedge sys_clk) disable iff (!reset_n)
        adcEnable_reg |-> portGOe_n[adcChannel_reg]) else $error("analog pin driven");
    chk_g_digital: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !adcEnable_reg |-> portGOe_n == ~portGDir_reg) else $error("port G digital drive wrong");
    chk_latch_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        doWrite && gpe_index(wAddr) == PORT_F_DATA_IDX |=> portFData_reg == $past(wByte))
        else $error("port F latch not written");
endmodule

/* verification/gpe_pin_model.sv */
// Board-side model of one port: resolves each pin from the block's drive and the board's level.
// Assumes enables are active low and the board drives only released pins.
`timescale 1ns/100ps
module gpe_pin_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] padOut, // Drive from the block
    input wire logic [W-1:0] padOe_n, // Enable, low drives
    input wire logic [W-1:0] boardLevel, // Level the board applies
    output logic [W-1:0] pinLevel // Resolved wire level
);
    // Block wins where it drives; else board level, never a stale value
    assign pinLevel = (~padOe_n & padOut) | (padOe_n & boardLevel);
endmodule

/* verification/gpio_ports_e_f_g_bench.sv */
// Self-checking bench for the port E/F/G block over AXI4-Lite.
// Assumes gpe_pkg, gpe_ports and the pin model are compiled first.
`timescale 1ns/100ps
module gpio_ports_e_f_g_bench;
    import gpe_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sysClk = 0, resetN = 0, awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0, txD = 0;
    logic [ADDR_W-1:0] awAddr = 0, arAddr = 0;
    logic [31:0] wData = 0;
    logic [3:0] wStrb = 4'hF, tOut = 0, tEn = 0;
    wire awReady, wReady, bValid, arReady, rValid, rxD;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    wire [5:0] pinE, eOut, eOe;
    wire [7:0] pinF, pinG, fOut, fOe, gOut, gOe, anaSel;
    wire [3:0] tIn;
    logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] lat [3], msk [3] = '{8'h3F, 8'hFF, 8'hFF}, rnd = 8'h4F;
    logic [11:0] dIdx [3] = '{PORT_E_DATA_IDX, PORT_F_DATA_IDX, PORT_G_DATA_IDX};
    logic [11:0] rIdx [3] = '{PORT_E_DIR_IDX, PORT_F_DIR_IDX, PORT_G_DIR_IDX};
    logic [33:0] expQ [$];
    int fails = 0, nTests = 0;
    // Clock at 40 ns
    initial forever #20 sysClk = ~sysClk;
    gpe_ports dut_u (.sys_clk(sysClk), .reset_n(resetN), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .portEIn(pinE), .portEOut(eOut),
        .portEOe_n(eOe), .portFIn(pinF), .portFOut(fOut), .portFOe_n(fOe), .portGIn(pinG), .portGOut(gOut),
        .portGOe_n(gOe), .analogSelect(anaSel), .serialTxData(txD), .serialRxData(rxD), .timerOut(tOut),
        .timerOutEn(tEn), .timerIn(tIn));
    gpe_pin_model #(.W(6)) pm_e (.padOut(eOut), .padOe_n(eOe), .boardLevel(ext[0][5:0]), .pinLevel(pinE));
    gpe_pin_model #(.W(8)) pm_f (.padOut(fOut), .padOe_n(fOe), .boardLevel(ext[1]), .pinLevel(pinF));
    gpe_pin_model #(.W(8)) pm_g (.padOut(gOut), .padOe_n(gOe), .boardLevel(ext[2]), .pinLevel(pinG));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        int i;
        awAddr <= {idx, 2'b00}; wData <= d; awValid <= 1; wValid <= 1; bReady <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge sysClk);
            if (awReady) awValid <= 0;
            if (wReady) wValid <= 0;
            if (bValid) break;
        end
        bReady <= 0;
        if (i == 50) begin fails++; test_done; end
        cmp({30'h0, bResp}, {30'h0, RESP_OKAY});
        @(posedge sysClk);
    endtask
    // Read: expectation queued before the request goes out
    task automatic rd(input logic [11:0] idx, input logic [33:0] e);
        int i;
        expQ.push_back(e);
        arAddr <= {idx, 2'b00}; arValid <= 1; rReady <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge sysClk);
            if (arReady) arValid <= 0;
            if (rValid) break;
        end
        rReady <= 0;
        if (i == 50) begin fails++; test_done; end
        @(posedge sysClk);
    endtask
    // Monitor: error reads carry no defined data, so only the code is compared
    always @(posedge sysClk) begin
        if (rValid && rReady) begin
            if (expQ.size() == 0) begin
                fails++;
                $display("unexpected at %0t: got %h exp none", $time, rData);
            end
            else begin
                cmp({30'h0, rResp}, {30'h0, expQ[0][33:32]});
                if (expQ[0][33:32] !== RESP_SLVERR) cmp(rData, expQ[0][31:0]);
                void'(expQ.pop_front());
            end
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge sysClk);
        resetN <= 1;
        @(posedge sysClk);
        for (int k = 0; k < 3; k++) rd(rIdx[k], 34'h0);
        @(negedge sysClk) cmp(fOe, 8'hFF);
        @(posedge sysClk);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            lat[k] = rnd;
            wr(dIdx[k], {24'h0, rnd});
            wr(rIdx[k], 32'hFF);
            rd(rIdx[k], {26'h0, msk[k]});
            rd(dIdx[k], {26'h0, rnd & msk[k]});
        end
        @(negedge sysClk) cmp({fOut, gOut, fOe}, {lat[1], lat[2], 8'h00});
        @(posedge sysClk);
        // Low four pins outputs, the rest inputs; then write the whole latch inverted
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            ext[k] <= rnd;
            wr(rIdx[k], 32'h0F);
        end
        repeat (3) @(posedge sysClk);
        for (int k = 0; k < 3; k++) begin
            rd(dIdx[k], {26'h0, ((lat[k] & 8'h0F) | (ext[k] & 8'hF0)) & msk[k]});
            lat[k] = ~lat[k];
            wr(dIdx[k], {24'h0, lat[k]});
            rd(dIdx[k], {26'h0, ((lat[k] & 8'h0F) | (ext[k] & 8'hF0)) & msk[k]});
        end
        rd(12'h001, {RESP_SLVERR, 32'h0});
        // Serial, converter channel 3 and timer channel 0 take their pins
        wr(PORT_E_DIR_IDX, 32'h00);
        txD <= 1; tOut <= 4'h1; tEn <= 4'h1;
        wr(PERIPH_CTRL_IDX, 32'h0133);
        repeat (3) @(posedge sysClk);
        @(negedge sysClk) cmp({eOut[0], eOe[0], rxD}, {1'b1, 1'b0, ext[0][1]});
        cmp(anaSel, 8'h08);
        cmp(gOe, 8'hF8);
        cmp(fOut[4], 1'b1);
        cmp(tIn, 4'h1);
        @(posedge sysClk);
        rd(PORT_E_DATA_IDX, {28'h0, ext[0][5:1], 1'b1});
        // Reset in mid-run keeps the latch
        resetN <= 0;
        repeat (2) @(posedge sysClk);
        resetN <= 1;
        @(posedge sysClk);
        rd(PORT_E_DIR_IDX, 34'h0);
        wr(PORT_E_DIR_IDX, 32'h3F);
        rd(PORT_E_DATA_IDX, {26'h0, lat[0] & 8'h3F});
        test_done;
    end
endmodule
